// *** hw/ckg_pkg.sv ***
// Constants, types and decode functions for the clock generator control
package ckg_pkg;

  // Register addresses
  localparam logic [15:0] CKG_ADDR_SLOW   = 16'hFF58;
  localparam logic [15:0] CKG_ADDR_FAST   = 16'hFF5A;
  localparam logic [15:0] CKG_ADDR_PRESC  = 16'hFFF3;
  localparam logic [15:0] CKG_ADDR_WSEL   = 16'hFFF4;
  localparam logic [15:0] CKG_ADDR_CPUDIV = 16'hFFFB;

  // Field positions
  localparam int CKG_BIT_HALT     = 0;
  localparam int CKG_BIT_CPUDIV   = 1;
  localparam int CKG_BIT_PRESC_LO = 0;
  localparam int CKG_BIT_PRESC_HI = 1;
  localparam int CKG_BIT_WSEL_LO  = 0;
  localparam int CKG_BIT_WSEL_HI  = 1;

  // Reset values
  localparam logic [7:0] CKG_RST_SLOW   = 8'h00;
  localparam logic [7:0] CKG_RST_FAST   = 8'h00;
  localparam logic [7:0] CKG_RST_PRESC  = 8'h02;
  localparam logic [7:0] CKG_RST_CPUDIV = 8'h02;

  // Timing: system clock rate and stabilization exponents
  localparam int CKG_SYS_CLK_HZ   = 10_000_000;
  localparam int CKG_WAIT_EXP0    = 10;
  localparam int CKG_WAIT_EXP1    = 12;
  localparam int CKG_WAIT_EXP2    = 15;
  localparam int CKG_WAIT_EXP3    = 17;
  localparam int CKG_WAIT_W       = 18;
  localparam int CKG_INSTR_CLKS   = 2;

  // Divider geometry: shift 0..4, counter spans the largest ratio
  localparam int CKG_SHIFT_W = 3;
  localparam int CKG_CNT_W   = 4;

  typedef enum logic [1:0] {
    CKG_SRC_FAST = 2'b00,
    CKG_SRC_XTAL = 2'b01,
    CKG_SRC_EXT  = 2'b10
  } ckg_src_e;

  // Build-time configuration
  typedef struct packed {
    ckg_src_e   src;
    logic       slow_stoppable;
    logic [1:0] por_wait;
  } ckg_cfg_s;

  // Oscillator and pin controls
  typedef struct packed {
    logic fast_osc_en;
    logic xtal_osc_en;
    logic ext_clk_pass;
    logic slow_osc_en;
    logic wdt_src_fixed;
    logic pin1_port;
    logic pin2_port;
  } ckg_osc_s;

  typedef enum logic [2:0] {
    CKG_ST_POR   = 3'b000,
    CKG_ST_WAIT  = 3'b001,
    CKG_ST_RUN   = 3'b010,
    CKG_ST_STOP  = 3'b011,
    CKG_ST_START = 3'b100
  } ckg_state_e;

  // CPU clock shift from prescaler and CPU divider bit
  function automatic logic [CKG_SHIFT_W-1:0] ckg_cpu_shift(
    input logic [1:0] presc,
    input logic       div
  );
    case ({presc, div})
      3'b000:  ckg_cpu_shift = 3'h0;
      3'b010:  ckg_cpu_shift = 3'h1;
      3'b001:  ckg_cpu_shift = 3'h2;
      3'b100:  ckg_cpu_shift = 3'h2;
      3'b011:  ckg_cpu_shift = 3'h3;
      3'b101:  ckg_cpu_shift = 3'h4;
      default: ckg_cpu_shift = 3'h4;
    endcase
  endfunction

  // Peripheral clock shift from prescaler alone
  function automatic logic [CKG_SHIFT_W-1:0] ckg_periph_shift(
    input logic [1:0] presc
  );
    case (presc)
      2'b00:   ckg_periph_shift = 3'h0;
      2'b01:   ckg_periph_shift = 3'h1;
      default: ckg_periph_shift = 3'h2;
    endcase
  endfunction

endpackage

// *** hw/ckg_div.sv ***
// Power-of-two clock enable divider with aligned ratio switching
`timescale 1ns/1ns
module ckg_div
  import ckg_pkg::*;
#(
  parameter int SHIFT_W = CKG_SHIFT_W,
  parameter int CNT_W   = CKG_CNT_W
)
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Control
  input  wire logic               run,
  input  wire logic [SHIFT_W-1:0] shift_sel,
  // Enable out
  output logic                    clk_en
);

  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [SHIFT_W-1:0] cur_r;
  logic [SHIFT_W-1:0] cur_nxt;
  logic               en_r;
  logic               en_nxt;

  always_comb
  begin
    cnt_nxt = run ? cnt_r + 1'b1 : '0;
    // Ratio only changes where all ratios share a boundary
    cur_nxt = (cnt_r == '0) ? shift_sel : cur_r;
    en_nxt  = run && ((cnt_r & ~({CNT_W{1'b1}} << cur_r)) == '0);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      cur_r <= '0;
      en_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
      en_r  <= en_nxt;
    end
  end

  assign clk_en = en_r;

  a_ratio_aligned: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(cur_r) |-> $past(cnt_r) == '0)
    else $error("divider ratio changed off boundary");

  a_half_spacing: assert property (
    @(posedge mclk) disable iff (rst)
    (en_r && cur_r == 3'h1 && $stable(cur_r) && run) |=> !en_r)
    else $error("divide by two enable came back to back");

endmodule

// *** hw/ckg_top.sv ***
// Clock generator control: registers, dividers, stop and wait sequencing
`timescale 1ns/1ns
module ckg_top
  import ckg_pkg::*;
#(
  parameter int WAIT_CYC0 = 1 << CKG_WAIT_EXP0,
  parameter int WAIT_CYC1 = 1 << CKG_WAIT_EXP1,
  parameter int WAIT_CYC2 = 1 << CKG_WAIT_EXP2,
  parameter int WAIT_CYC3 = 1 << CKG_WAIT_EXP3
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Build-time configuration
  input  wire ckg_cfg_s    cfg,
  // Register access
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [7:0]       rdata,
  // Power control
  input  wire logic        stop_req,
  input  wire logic        wake_req,
  input  wire logic        osc_started_pin,
  // Clock and oscillator controls
  output ckg_osc_s         osc,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             instr_slot,
  output logic             clk_ready
);

  // Register group
  logic       slow_halt_r;
  logic       slow_halt_nxt;
  logic       fast_halt_r;
  logic       fast_halt_nxt;
  logic [1:0] presc_r;
  logic [1:0] presc_nxt;
  logic       cpudiv_r;
  logic       cpudiv_nxt;
  logic [1:0] wsel_r;
  logic [1:0] wsel_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Sequencer group
  ckg_state_e            state_r;
  ckg_state_e            state_nxt;
  logic [CKG_WAIT_W-1:0] wcnt_r;
  logic [CKG_WAIT_W-1:0] wcnt_nxt;
  logic                  osc_s1_r;
  logic                  osc_s2_r;

  // Output group
  ckg_osc_s osc_r;
  ckg_osc_s osc_nxt;
  logic     half_r;
  logic     half_nxt;
  logic     slot_r;
  logic     slot_nxt;
  logic     ready_r;
  logic     ready_nxt;

  logic cpu_en;
  logic per_en;
  logic running;

  // Wait length as a terminal count
  function automatic logic [CKG_WAIT_W-1:0] wait_load(input logic [1:0] sel);
    case (sel)
      2'b00:   wait_load = CKG_WAIT_W'(WAIT_CYC0 - 1);
      2'b01:   wait_load = CKG_WAIT_W'(WAIT_CYC1 - 1);
      2'b10:   wait_load = CKG_WAIT_W'(WAIT_CYC2 - 1);
      default: wait_load = CKG_WAIT_W'(WAIT_CYC3 - 1);
    endcase
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // Register writes and reads
  always_comb
  begin
    slow_halt_nxt = slow_halt_r;
    fast_halt_nxt = fast_halt_r;
    presc_nxt     = presc_r;
    cpudiv_nxt    = cpudiv_r;
    wsel_nxt      = wsel_r;
    rdata_nxt     = rdata_r;
    if (wr_en)
    begin
      if (hit(addr, CKG_ADDR_SLOW) && cfg.slow_stoppable)
        slow_halt_nxt = wdata[CKG_BIT_HALT];
      if (hit(addr, CKG_ADDR_FAST) && cfg.src != CKG_SRC_FAST)
        fast_halt_nxt = wdata[CKG_BIT_HALT];
      if (hit(addr, CKG_ADDR_PRESC))
        presc_nxt = wdata[CKG_BIT_PRESC_HI:CKG_BIT_PRESC_LO];
      if (hit(addr, CKG_ADDR_CPUDIV))
        cpudiv_nxt = wdata[CKG_BIT_CPUDIV];
      if (hit(addr, CKG_ADDR_WSEL))
        wsel_nxt = wdata[CKG_BIT_WSEL_HI:CKG_BIT_WSEL_LO];
    end
    if (rd_en)
    begin
      rdata_nxt = 8'h00;
      if (hit(addr, CKG_ADDR_SLOW))
        rdata_nxt[CKG_BIT_HALT] = slow_halt_r;
      if (hit(addr, CKG_ADDR_FAST))
        rdata_nxt[CKG_BIT_HALT] = fast_halt_r;
      if (hit(addr, CKG_ADDR_PRESC))
        rdata_nxt[CKG_BIT_PRESC_HI:CKG_BIT_PRESC_LO] = presc_r;
      if (hit(addr, CKG_ADDR_CPUDIV))
        rdata_nxt[CKG_BIT_CPUDIV] = cpudiv_r;
      if (hit(addr, CKG_ADDR_WSEL))
        rdata_nxt[CKG_BIT_WSEL_HI:CKG_BIT_WSEL_LO] = wsel_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slow_halt_r <= CKG_RST_SLOW[CKG_BIT_HALT];
      fast_halt_r <= CKG_RST_FAST[CKG_BIT_HALT];
      presc_r     <= CKG_RST_PRESC[CKG_BIT_PRESC_HI:CKG_BIT_PRESC_LO];
      cpudiv_r    <= CKG_RST_CPUDIV[CKG_BIT_CPUDIV];
      rdata_r     <= 8'h00;
    end
    else
    begin
      slow_halt_r <= slow_halt_nxt;
      fast_halt_r <= fast_halt_nxt;
      presc_r     <= presc_nxt;
      cpudiv_r    <= cpudiv_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // Wait select keeps whatever it holds across reset
  always_ff @(posedge mclk)
  begin
    wsel_r <= wsel_nxt;
  end

  // Oscillation-start indication from the analog side
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
    end
    else
    begin
      osc_s1_r <= osc_started_pin;
      osc_s2_r <= osc_s1_r;
    end
  end

  // Start, stop and stabilization sequencing
  always_comb
  begin
    state_nxt = state_r;
    wcnt_nxt  = wcnt_r;
    case (state_r)
      CKG_ST_POR:
      begin
        if (cfg.src != CKG_SRC_XTAL)
          state_nxt = CKG_ST_RUN;
        else if (osc_s2_r)
        begin
          state_nxt = CKG_ST_WAIT;
          wcnt_nxt  = wait_load(cfg.por_wait);
        end
      end
      CKG_ST_WAIT:
      begin
        if (wcnt_r == '0)
          state_nxt = CKG_ST_RUN;
        else
          wcnt_nxt = wcnt_r - 1'b1;
      end
      CKG_ST_RUN:
      begin
        if (stop_req)
          state_nxt = CKG_ST_STOP;
      end
      CKG_ST_STOP:
      begin
        if (wake_req)
          state_nxt = (cfg.src == CKG_SRC_XTAL) ? CKG_ST_START
                                                : CKG_ST_RUN;
      end
      CKG_ST_START:
      begin
        if (osc_s2_r)
        begin
          state_nxt = CKG_ST_WAIT;
          wcnt_nxt  = wait_load(wsel_r);
        end
      end
      default:
      begin
        state_nxt = CKG_ST_POR;
        wcnt_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= CKG_ST_POR;
      wcnt_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      wcnt_r  <= wcnt_nxt;
    end
  end

  assign running = (state_r == CKG_ST_RUN);

  // Clock enables for CPU and peripheral domains
  ckg_div u_cpu_div (
    .mclk      (mclk),
    .rst       (rst),
    .run       (running),
    .shift_sel (ckg_cpu_shift(presc_r, cpudiv_r)),
    .clk_en    (cpu_en)
  );

  ckg_div u_per_div (
    .mclk      (mclk),
    .rst       (rst),
    .run       (running),
    .shift_sel (ckg_periph_shift(presc_r)),
    .clk_en    (per_en)
  );

  // Oscillator, pin and instruction slot controls
  always_comb
  begin
    osc_nxt.fast_osc_en   = (cfg.src == CKG_SRC_FAST)
                            ? (state_r != CKG_ST_STOP)
                            : !fast_halt_r;
    osc_nxt.xtal_osc_en   = (cfg.src == CKG_SRC_XTAL)
                            && (state_r != CKG_ST_STOP);
    osc_nxt.ext_clk_pass  = (cfg.src == CKG_SRC_EXT)
                            && (state_r != CKG_ST_STOP);
    osc_nxt.slow_osc_en   = !(cfg.slow_stoppable && slow_halt_r);
    osc_nxt.wdt_src_fixed = !cfg.slow_stoppable;
    osc_nxt.pin1_port     = (cfg.src == CKG_SRC_FAST);
    osc_nxt.pin2_port     = (cfg.src != CKG_SRC_XTAL);
    half_nxt  = cpu_en ? !half_r : half_r;
    slot_nxt  = cpu_en && half_r;
    ready_nxt = running;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      osc_r   <= '0;
      half_r  <= 1'b0;
      slot_r  <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      osc_r   <= osc_nxt;
      half_r  <= half_nxt;
      slot_r  <= slot_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign osc           = osc_r;
  assign rdata         = rdata_r;
  assign cpu_clk_en    = cpu_en;
  assign periph_clk_en = per_en;
  assign instr_slot    = slot_r;
  assign clk_ready     = ready_r;

  a_stop_halts: assert property (
    @(posedge mclk) disable iff (rst)
    state_r == CKG_ST_STOP |=> !osc_r.xtal_osc_en && !osc_r.ext_clk_pass)
    else $error("source still active in stop mode");

  a_fast_pins: assert property (
    @(posedge mclk) disable iff (rst)
    osc_r.pin1_port |-> osc_r.pin2_port && !osc_r.xtal_osc_en)
    else $error("pin release inconsistent with fast source");

  a_ext_pins: assert property (
    @(posedge mclk) disable iff (rst)
    (cfg.src == CKG_SRC_EXT && $stable(cfg))
    |=> !osc_r.pin1_port && osc_r.pin2_port)
    else $error("external clock pin release wrong");

  a_slow_locked: assert property (
    @(posedge mclk) disable iff (rst)
    (!cfg.slow_stoppable && $stable(cfg))
    |=> osc_r.slow_osc_en && osc_r.wdt_src_fixed)
    else $error("slow oscillator not locked on");

  a_slow_reset: assert property (
    @(posedge mclk)
    rst |=> !slow_halt_r && !fast_halt_r)
    else $error("mode registers not cleared by reset");

  a_div_reset: assert property (
    @(posedge mclk)
    rst |=> presc_r == 2'b10 && cpudiv_r)
    else $error("divider registers not 02H after reset");

  a_fast_ignored: assert property (
    @(posedge mclk) disable iff (rst)
    (wr_en && addr == CKG_ADDR_FAST && cfg.src == CKG_SRC_FAST)
    |=> $stable(fast_halt_r))
    else $error("fast register written under fast source");

  a_no_wait: assert property (
    @(posedge mclk) disable iff (rst)
    (state_r == CKG_ST_STOP && wake_req && cfg.src != CKG_SRC_XTAL)
    |=> state_r == CKG_ST_RUN)
    else $error("wait inserted for non crystal source");

  a_wait_after_start: assert property (
    @(posedge mclk) disable iff (rst)
    (state_r == CKG_ST_START && !osc_s2_r) |=> state_r != CKG_ST_WAIT)
    else $error("wait counted before oscillation start");

  a_wait_held: assert property (
    @(posedge mclk) disable iff (rst)
    (state_r == CKG_ST_START && osc_s2_r && wsel_r == 2'b00)
    |=> (state_r == CKG_ST_WAIT) [*8])
    else $error("stabilization wait ended early");

  a_instr_pair: assert property (
    @(posedge mclk) disable iff (rst)
    slot_r |-> $past(cpu_en) && !$past(slot_r))
    else $error("instruction slot not on second CPU clock");

endmodule

// *** testbench/test_system_clock_generator_control.sv ***
// Self-checking testbench for the clock generator control block
`timescale 1ns/1ns
module test_system_clock_generator_control;
  import ckg_pkg::*;
  localparam int WC [4] = '{10, 16, 32, 64};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  ckg_cfg_s    cfg;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        stop_req;
  logic        wake_req;
  logic        osc_started_pin;
  ckg_osc_s    osc;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        instr_slot;
  logic        clk_ready;
  int          miscompares = 0;
  int          n_checks = 0;
  ckg_top #(.WAIT_CYC0(10), .WAIT_CYC1(16), .WAIT_CYC2(32), .WAIT_CYC3(64))
  dut_u (.mclk(mclk), .rst(rst), .cfg(cfg), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .stop_req(stop_req),
    .wake_req(wake_req), .osc_started_pin(osc_started_pin), .osc(osc),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .instr_slot(instr_slot), .clk_ready(clk_ready));
  always #50 mclk = ~mclk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic do_reset(input ckg_src_e s, input logic stp,
                          input logic [1:0] pw, input logic pin);
    @(negedge mclk);
    rst = 1'b1;
    cfg = '{src: s, slow_stoppable: stp, por_wait: pw};
    osc_started_pin = pin;
    cyc(4);
    rst = 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    rd_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
    @(negedge mclk);
    check(rdata, exp);
  endtask
  // Cycles until clk_ready, bounded
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (clk_ready !== 1'b1)
    begin
      @(negedge mclk);
      cnt++;
      if (cnt > 400)
      begin
        miscompares++;
        $display("mismatch at %0t: clock never ready", $time);
        final_report();
      end
    end
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? cpu_clk_en : (w == 1 ? periph_clk_en : instr_slot);
  endfunction
  // Gap in cycles between two consecutive enable pulses
  task automatic gap(input int w, output int g);
    int t;
    t = 0;
    g = 0;
    while (pick(w) !== 1'b1 && t < 40)
    begin
      @(negedge mclk);
      t++;
    end
    do
    begin
      @(negedge mclk);
      g++;
    end
    while (pick(w) !== 1'b1 && g < 40);
    if (t >= 40 || g >= 40)
    begin
      miscompares++;
      $display("mismatch at %0t: enable pulse missing", $time);
      final_report();
    end
  endtask
  task automatic sc_reset_values();
    int n;
    do_reset(CKG_SRC_FAST, 1'b1, 2'b00, 1'b0);
    wait_ready(n);
    check(n <= 4, 1);
    rd_chk(CKG_ADDR_CPUDIV, 8'h02);
    rd_chk(CKG_ADDR_PRESC, 8'h02);
    rd_chk(CKG_ADDR_SLOW, 8'h00);
    rd_chk(CKG_ADDR_FAST, 8'h00);
    rd_chk(16'hFF00, 8'h00);
    check({osc.pin1_port, osc.pin2_port}, 2'b11);
    check({osc.fast_osc_en, osc.slow_osc_en}, 2'b11);
    check(osc.wdt_src_fixed, 1'b0);
  endtask
  task automatic sc_reg_masks();
    wr(CKG_ADDR_SLOW, 8'hFF);
    rd_chk(CKG_ADDR_SLOW, 8'h01);
    check(osc.slow_osc_en, 1'b0);
    wr(CKG_ADDR_SLOW, 8'h00);
    cyc(2);
    check(osc.slow_osc_en, 1'b1);
    wr(CKG_ADDR_FAST, 8'h01);
    rd_chk(CKG_ADDR_FAST, 8'h00);
    wr(CKG_ADDR_WSEL, 8'hFF);
    rd_chk(CKG_ADDR_WSEL, 8'h03);
    wr(CKG_ADDR_CPUDIV, 8'hFF);
    rd_chk(CKG_ADDR_CPUDIV, 8'h02);
  endtask
  task automatic sc_ratios();
    logic [1:0] pr [6] = '{2'b00, 2'b01, 2'b00, 2'b10, 2'b01, 2'b10};
    logic       dv [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int         cr [6] = '{1, 2, 4, 4, 8, 16};
    int         prr [6] = '{1, 2, 1, 4, 2, 4};
    int         g;
    for (int i = 0; i < 6; i++)
    begin
      wr(CKG_ADDR_PRESC, {6'h00, pr[i]});
      wr(CKG_ADDR_CPUDIV, {6'h00, dv[i], 1'b0});
      cyc(40);
      gap(0, g);
      check(g, cr[i]);
      gap(1, g);
      check(g, prr[i]);
      gap(2, g);
      check(g, CKG_INSTR_CLKS * cr[i]);
      gap(0, g);
      check(g, cr[i]);
    end
  endtask
  task automatic sc_ext_locked();
    int n;
    int pulses;
    do_reset(CKG_SRC_EXT, 1'b0, 2'b00, 1'b0);
    wait_ready(n);
    check({osc.pin1_port, osc.pin2_port}, 2'b01);
    check({osc.ext_clk_pass, osc.xtal_osc_en}, 2'b10);
    wr(CKG_ADDR_SLOW, 8'h01);
    rd_chk(CKG_ADDR_SLOW, 8'h00);
    check({osc.slow_osc_en, osc.wdt_src_fixed}, 2'b11);
    wr(CKG_ADDR_FAST, 8'h01);
    rd_chk(CKG_ADDR_FAST, 8'h01);
    check(osc.fast_osc_en, 1'b0);
    @(negedge mclk);
    stop_req = 1'b1;
    @(negedge mclk);
    stop_req = 1'b0;
    cyc(3);
    check({clk_ready, osc.ext_clk_pass}, 2'b00);
    pulses = 0;
    repeat (20)
    begin
      @(negedge mclk);
      pulses += cpu_clk_en;
    end
    check(pulses, 0);
    wake_req = 1'b1;
    @(negedge mclk);
    wake_req = 1'b0;
    wait_ready(n);
    check(n <= 3, 1);
    check(osc.ext_clk_pass, 1'b1);
    wr(CKG_ADDR_FAST, 8'h00);
    rd_chk(CKG_ADDR_FAST, 8'h00);
    check(osc.fast_osc_en, 1'b1);
  endtask
  task automatic sc_xtal_waits();
    int n;
    do_reset(CKG_SRC_XTAL, 1'b1, 2'b01, 1'b0);
    cyc(100);
    check(clk_ready, 1'b0);
    osc_started_pin = 1'b1;
    wait_ready(n);
    check(n >= WC[1] && n <= WC[1] + 8, 1);
    check({osc.pin1_port, osc.pin2_port, osc.xtal_osc_en}, 3'b001);
    for (int k = 0; k < 4; k++)
    begin
      wr(CKG_ADDR_WSEL, 8'(k));
      @(negedge mclk);
      stop_req = 1'b1;
      @(negedge mclk);
      stop_req = 1'b0;
      cyc(2);
      osc_started_pin = 1'b0;
      cyc(2);
      check({clk_ready, osc.xtal_osc_en}, 2'b00);
      wake_req = 1'b1;
      @(negedge mclk);
      wake_req = 1'b0;
      cyc(80);
      check(clk_ready, 1'b0);
      osc_started_pin = 1'b1;
      wait_ready(n);
      check(n >= WC[k] && n <= WC[k] + 8, 1);
    end
  endtask
  initial
  begin
    cfg = '{src: CKG_SRC_FAST, slow_stoppable: 1'b1, por_wait: 2'b00};
    addr = 16'h0000;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    stop_req = 1'b0;
    wake_req = 1'b0;
    osc_started_pin = 1'b0;
    sc_reset_values();
    sc_reg_masks();
    sc_ratios();
    sc_ext_locked();
    sc_xtal_waits();
    final_report();
  end
endmodule
